// File: seq_pkg.sv
// package: constants and types for the line transmit sequencer
package seq_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ASTER_BIT = 1;
  localparam int CTRL_BREAK_BIT = 2;

  // ----------------------------------------------------------------
  // timing and characters
  // ----------------------------------------------------------------
  localparam int BREAK_MS = 300;
  localparam int PAUSE_MS = 200;
  localparam int BREAK_CYCLES = 3;
  localparam int PAUSE_CYCLES = 2;
  localparam logic [7:0] EOT_CHAR   = 8'h84; // bits 3 and 8 marking
  localparam logic [7:0] START_CHAR = 8'h90; // bits 5 and 8 marking
  localparam logic [7:0] ASTER_CHAR = 8'hAA; // bits 2,4,6,8
  localparam logic [7:0] ACK_CHAR   = 8'hFC; // bits 3..8
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    IDLE  = 3'h0,
    NORM  = 3'h1,
    BREAK = 3'h3,
    EOT   = 3'h2
  } mode_t;

  // counter halves: first and second half for each stage
  typedef struct packed {
    logic stage_three_second_half;
    logic c;
    logic stage_two_second_half;
    logic b;
    logic stage_one_second_half;
    logic a;
  } halves_t;

  // line outputs
  typedef struct packed {
    logic       start_drive;
    logic       line_open;
    logic       line_shunt;
    logic [7:0] char_bits;
  } line_t;

endpackage : seq_pkg

// File: line_transmit_sequencer.sv
// line transmit sequencer: three-stage counter paced by distributor timing contact
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Function
// - three stages, two halves, set by contact
// - no request: halves clear, drive off
// - start request and stepper still: drive on
// - first close sets stage-one first, drive off
// - first open sets stage-one second half
// - stage-one held during variable phase
// - second close sets stage-two first, drive off
// - second open ends phase, clears counter
// - asterisk response uses same counter sequence
// - break request drives, steps three stages
// - third close sets stage-three first, drive off
// - third open: eot phase, clear, drop break
// - line held open three cycles, 300 ms
// - break dropped in eot phase: drive on
// - line idle until stage-two second sets
// - eot character sent in stage-three cycle
// - stage-three second ends eot, clears halves
// - eot character bits 3 and 8 marking
// - first start character bits 5,8 marking
module line_transmit_sequencer (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          stepper_moving,
  input  wire logic          timing_contact,
  output seq_pkg::line_t     line_q
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  seq_pkg::halves_t h_q;
  seq_pkg::mode_t   mode_q;
  logic             contact_q;
  logic             start_code_request;
  logic             asterisk_response_phase;
  logic             line_break_request;
  logic             variable_q;     // second character phase
  logic             aster_q;        // current run is the response
  logic             pending_start_q;
  logic             pending_aster_q;
  logic             pending_break_q;
  logic             close_ev;
  logic             open_ev;
  logic             counter_clear;

  assign close_ev = timing_contact & ~contact_q;
  assign open_ev  = ~timing_contact & contact_q;
  assign counter_clear = (h_q == '0);
  assign start_code_request      = pending_start_q;
  assign asterisk_response_phase = pending_aster_q;
  assign line_break_request      = pending_break_q;

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic aw_seen_q, w_seen_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic        wr_fire;

  assign wr_fire = aw_seen_q & w_seen_q & ~s_axi_bvalid;

  // address and data taken in either order, response after both
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_seen_q     <= 1'b0;
      w_seen_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= seq_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_seen_q & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_seen_q & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_seen_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_seen_q <= 1'b1;
        wdata_q  <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_seen_q    <= 1'b0;
        w_seen_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == seq_pkg::CTRL_OFF || awaddr_q == seq_pkg::STATUS_OFF)
                        ? seq_pkg::RESP_OKAY : seq_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic ctrl_wr;
  assign ctrl_wr = wr_fire & (awaddr_q == seq_pkg::CTRL_OFF);

  // read channel: status shows counter halves, mode and variable phase; control shows pending requests
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= seq_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= seq_pkg::RESP_OKAY;
        case (s_axi_araddr)
          seq_pkg::CTRL_OFF:
            s_axi_rdata <= {29'h0, pending_break_q, pending_aster_q, pending_start_q};
          seq_pkg::STATUS_OFF:
            s_axi_rdata <= {22'h0, variable_q, mode_q, h_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= seq_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // requests
  // ----------------------------------------------------------------
  logic accept;
  assign accept = ctrl_wr & (mode_q == seq_pkg::IDLE) & counter_clear
                  & ~pending_start_q & ~pending_aster_q & ~pending_break_q;

  // request latches; clear from the sequence wins only when no new request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pending_start_q <= 1'b0;
      pending_aster_q <= 1'b0;
      pending_break_q <= 1'b0;
    end else begin
      if (mode_q == seq_pkg::NORM && open_ev && !h_q.stage_one_second_half)
        {pending_start_q, pending_aster_q} <= 2'b00;
      if (mode_q == seq_pkg::EOT && !h_q.stage_three_second_half && pending_break_q)
        pending_break_q <= 1'b0;
      if (accept) begin
        if (wdata_q[seq_pkg::CTRL_BREAK_BIT])
          pending_break_q <= 1'b1;
        else if (wdata_q[seq_pkg::CTRL_ASTER_BIT])
          pending_aster_q <= 1'b1;
        else if (wdata_q[seq_pkg::CTRL_START_BIT])
          pending_start_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // counter and mode
  // ----------------------------------------------------------------
  // contact level one clock late, so edges show as one-cycle events
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) contact_q <= 1'b0;
    else contact_q <= timing_contact;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      h_q        <= '0;
      mode_q     <= seq_pkg::IDLE;
      variable_q <= 1'b0;
      aster_q    <= 1'b0;
    end else begin
      case (mode_q)
        seq_pkg::IDLE: begin
          h_q <= '0;
          variable_q <= 1'b0;
          if (line_break_request) mode_q <= seq_pkg::BREAK;
          else if ((start_code_request | asterisk_response_phase) & ~stepper_moving) begin
            mode_q  <= seq_pkg::NORM;
            aster_q <= asterisk_response_phase;
          end
        end
        // start code and response share this path
        seq_pkg::NORM: begin
          if (close_ev && !h_q.stage_one_second_half) h_q.a <= 1'b1;
          else if (close_ev && h_q.stage_one_second_half) h_q.b <= 1'b1;
          // stage one held in variable phase
          if (open_ev && h_q.a && !h_q.stage_one_second_half) begin
            h_q.stage_one_second_half <= 1'b1;
            variable_q <= 1'b1;
          end
          if (open_ev && h_q.b) begin
            h_q        <= '0;
            variable_q <= 1'b0;
            mode_q     <= seq_pkg::IDLE;
          end
        end
        seq_pkg::BREAK, seq_pkg::EOT: begin
          if (close_ev) begin
            if (!h_q.stage_one_second_half) h_q.a <= 1'b1;
            else if (!h_q.stage_two_second_half) h_q.b <= 1'b1;
            else h_q.c <= 1'b1;
          end
          if (open_ev) begin
            if (h_q.a && !h_q.stage_one_second_half) h_q.stage_one_second_half <= 1'b1;
            else if (h_q.b && !h_q.stage_two_second_half) h_q.stage_two_second_half <= 1'b1;
            else if (h_q.c) h_q.stage_three_second_half <= 1'b1;
          end
          if (h_q.stage_three_second_half) begin
            h_q <= '0;
            mode_q <= (mode_q == seq_pkg::BREAK) ? seq_pkg::EOT : seq_pkg::IDLE;
          end
        end
        default: begin
          h_q    <= '0;
          mode_q <= seq_pkg::IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // line outputs
  // ----------------------------------------------------------------
  logic drive_d;
  logic [7:0] char_d;

  // drive on whenever the counter awaits the next contact close, except in eot phase until break is dropped
  always_comb begin
    drive_d = 1'b0;
    char_d  = 8'h00;
    case (mode_q)
      seq_pkg::NORM: begin
        // drive for first and variable cycles
        drive_d = (!h_q.a & !contact_q) | (h_q.stage_one_second_half & !h_q.b & !contact_q);
        if (!h_q.stage_one_second_half)
          char_d = aster_q ? seq_pkg::ASTER_CHAR : seq_pkg::START_CHAR;
        else char_d = aster_q ? seq_pkg::ACK_CHAR : 8'h00;
      end
      seq_pkg::BREAK,
      seq_pkg::EOT: begin
        drive_d = !h_q.c & !contact_q & !(mode_q == seq_pkg::EOT && pending_break_q)
                  & !(h_q.a & !h_q.stage_one_second_half) & !(h_q.b & !h_q.stage_two_second_half);
        if (mode_q == seq_pkg::EOT && h_q.stage_two_second_half) char_d = seq_pkg::EOT_CHAR;
      end
      default: drive_d = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      line_q <= '0;
    end else begin
      line_q.start_drive <= drive_d;
      line_q.line_open   <= (mode_q == seq_pkg::BREAK);
      line_q.line_shunt  <= (mode_q == seq_pkg::EOT) & ~h_q.stage_two_second_half;
      line_q.char_bits   <= char_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_idle_clear;
    @(posedge sys_clk) disable iff (rst)
      (mode_q == seq_pkg::IDLE) |=> (h_q == '0) || (mode_q != seq_pkg::IDLE);
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("idle counter not clear");

  property p_drive_off_close;
    @(posedge sys_clk) disable iff (rst)
      (mode_q == seq_pkg::NORM && close_ev) |=> ##1 !line_q.start_drive;
  endproperty
  a_drive_off_close: assert property (p_drive_off_close) else $error("drive on after close");

  property p_s1_set;
    @(posedge sys_clk) disable iff (rst)
      (mode_q == seq_pkg::NORM && open_ev && h_q.a && !h_q.stage_one_second_half)
      |=> h_q.stage_one_second_half && variable_q;
  endproperty
  a_s1_set: assert property (p_s1_set) else $error("stage-one second half missing");

  property p_s1_held;
    @(posedge sys_clk) disable iff (rst)
      (variable_q && h_q.stage_one_second_half && !open_ev) |=> h_q.stage_one_second_half && h_q.a;
  endproperty
  a_s1_held: assert property (p_s1_held) else $error("stage one dropped");

  property p_end_clear;
    @(posedge sys_clk) disable iff (rst)
      (mode_q == seq_pkg::NORM && open_ev && h_q.b) |=> h_q == '0 && mode_q == seq_pkg::IDLE;
  endproperty
  a_end_clear: assert property (p_end_clear) else $error("end not cleared");

  property p_break_open;
    @(posedge sys_clk) disable iff (rst)
      (mode_q == seq_pkg::BREAK) |=> line_q.line_open;
  endproperty
  a_break_open: assert property (p_break_open) else $error("line not open in break");

  property p_s3_clear;
    @(posedge sys_clk) disable iff (rst)
      h_q.stage_three_second_half |=> h_q == '0;
  endproperty
  a_s3_clear: assert property (p_s3_clear) else $error("stage three not cleared");

  property p_eot_char;
    @(posedge sys_clk) disable iff (rst)
      (mode_q == seq_pkg::EOT && h_q.stage_two_second_half)
      |=> line_q.char_bits == seq_pkg::EOT_CHAR;
  endproperty
  a_eot_char: assert property (p_eot_char) else $error("wrong eot character");

  property p_one_only;
    @(posedge sys_clk) disable iff (rst)
      (mode_q != seq_pkg::IDLE && ctrl_wr) |=> $stable(pending_break_q) || !pending_break_q;
  endproperty
  a_one_only: assert property (p_one_only) else $error("request taken while busy");

  c_start_done: cover property (@(posedge sys_clk) disable iff (rst)
    mode_q == seq_pkg::NORM ##[1:1000] mode_q == seq_pkg::IDLE);
  c_break_eot: cover property (@(posedge sys_clk) disable iff (rst)
    mode_q == seq_pkg::BREAK ##[1:1000] mode_q == seq_pkg::EOT);
  c_aster: cover property (@(posedge sys_clk) disable iff (rst) aster_q && h_q.b);

endmodule : line_transmit_sequencer

`default_nettype wire

// File: distributor_model.sv
// distributor_model: behavioural transmitting distributor with its timing contact
`timescale 1ns/100ps
`default_nettype none

module distributor_model (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start_drive,
  input  wire logic slow,
  output logic      timing_contact
);
  logic [5:0] cnt_q;
  logic       busy_q;
  logic [5:0] lag;

  // ------------------------------------------------------------
  // one character cycle per clutch pull
  // ------------------------------------------------------------
  // slow mode leaves room for register reads between cycles
  assign lag = slow ? 6'h14 : 6'h02;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_q         <= 1'b0;
      cnt_q          <= 6'h00;
      timing_contact <= 1'b0;
    end else if (!busy_q) begin
      timing_contact <= 1'b0;
      cnt_q          <= 6'h00;
      busy_q         <= start_drive;
    end else begin
      cnt_q <= cnt_q + 6'h01;
      if (cnt_q == lag) timing_contact <= 1'b1; // contact closes
      if (cnt_q == lag + 6'h08) begin
        timing_contact <= 1'b0; // contact opens, cycle over
        busy_q         <= 1'b0;
      end
    end
  end
endmodule : distributor_model

`default_nettype wire

// File: test_line_transmit_sequencer.sv
// test_line_transmit_sequencer: self-checking bench for the transmit sequencer
`timescale 1ns/100ps
`default_nettype none

module test_line_transmit_sequencer;
  logic sys_clk = 1'b0, rst = 1'b1, stepper_moving = 1'b0, slow = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic timing_contact;
  seq_pkg::line_t line_q;
  seq_pkg::line_t rec [8];
  logic [7:0] pulses = 8'h00, hi_cnt = 8'h00, b;
  logic [31:0] rd;
  int num_errors = 0, num_checks = 0, cyc = 0;

  always #12.5 sys_clk = ~sys_clk;

  line_transmit_sequencer u_line_transmit_sequencer (
    .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .stepper_moving(stepper_moving), .timing_contact(timing_contact), .line_q(line_q));

  distributor_model u_distributor_model (.sys_clk(sys_clk), .rst(rst),
    .start_drive(line_q.start_drive), .slow(slow), .timing_contact(timing_contact));

  // ------------------------------------------------------------
  // monitor: snapshot of the line outputs mid-way through each contact closure
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    hi_cnt <= timing_contact ? hi_cnt + 8'h01 : 8'h00;
    if (timing_contact && hi_cnt == 8'h04) begin
      rec[pulses[2:0]] <= line_q;
      pulses           <= pulses + 8'h01;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge sys_clk);
      if (!aw_done && s_axi_awready === 1'b1) begin aw_done = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!w_done && s_axi_wready === 1'b1) begin w_done = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  // wait for n character cycles, then check the counter has gone quiet
  task automatic wait_done(input logic [7:0] n);
    while (pulses != b + n) @(posedge sys_clk);
    repeat (40) @(posedge sys_clk);
    check("cycle count", {24'h0, pulses}, {24'h0, b + n});
    check("drive idle", {31'h0, line_q.start_drive}, 32'h0);
    axi_read(seq_pkg::STATUS_OFF, rd, resp);
    check("status idle", rd[9:0], 32'h0);
  endtask : wait_done

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check("line after reset", line_q, 11'h000);
    axi_read(seq_pkg::STATUS_OFF, rd, resp);
    check("status after reset", rd, 32'h0);
    axi_read(8'h10, rd, resp);
    check("unmapped resp", resp, seq_pkg::RESP_SLVERR);
  endtask : t_reset

  task automatic t_start();
    int i;
    b = pulses;
    slow <= 1'b1;
    stepper_moving <= 1'b1;
    axi_write(seq_pkg::CTRL_OFF, 32'h1, resp);
    check("start write resp", resp, seq_pkg::RESP_OKAY);
    repeat (10) @(posedge sys_clk);
    check("drive held by stepper", line_q.start_drive, 1'b0);
    stepper_moving <= 1'b0;
    for (i = 0; i < 20 && line_q.start_drive !== 1'b1; i++) @(posedge sys_clk);
    check("drive after stepper", line_q.start_drive, 1'b1);
    while (pulses != b + 8'h01) @(posedge sys_clk);
    while (timing_contact) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
    axi_read(seq_pkg::STATUS_OFF, rd, resp);
    check("stage one halves", rd[5:0], 32'h03);
    check("variable phase", rd[9], 1'b1);
    check("drive again", line_q.start_drive, 1'b1);
    wait_done(8'h02);
    check("first char", rec[b[2:0]].char_bits, seq_pkg::START_CHAR);
    check("drive off cyc1", rec[b[2:0]].start_drive, 1'b0);
    slow <= 1'b0;
  endtask : t_start

  task automatic t_aster();
    b = pulses;
    axi_write(seq_pkg::CTRL_OFF, 32'h2, resp);
    while (pulses != b + 8'h01) @(posedge sys_clk);
    // a break request in mid-sequence must be dropped
    axi_write(seq_pkg::CTRL_OFF, 32'h4, resp);
    wait_done(8'h02);
    check("asterisk char", rec[b[2:0]].char_bits, seq_pkg::ASTER_CHAR);
    check("ack char", rec[3'(b + 8'h01)].char_bits, seq_pkg::ACK_CHAR);
    check("drive off cyc2", rec[3'(b + 8'h01)].start_drive, 1'b0);
    check("no break", rec[3'(b + 8'h01)].line_open, 1'b0);
    axi_read(seq_pkg::CTRL_OFF, rd, resp);
    check("nothing pending", rd[2:0], 32'h0);
  endtask : t_aster

  task automatic t_break();
    int i;
    b = pulses;
    axi_write(seq_pkg::CTRL_OFF, 32'h4, resp);
    wait_done(8'h06);
    for (i = 0; i < 3; i++) begin
      check("break open", rec[3'(b + i[7:0])].line_open, 1'b1);
      check("break drive off", rec[3'(b + i[7:0])].start_drive, 1'b0);
    end
    for (i = 3; i < 5; i++) begin
      check("pause shunt", rec[3'(b + i[7:0])].line_shunt, 1'b1);
      check("pause closed", rec[3'(b + i[7:0])].line_open, 1'b0);
    end
    check("eot char", rec[3'(b + 8'h05)].char_bits, seq_pkg::EOT_CHAR);
    check("eot unshunted", rec[3'(b + 8'h05)].line_shunt, 1'b0);
  endtask : t_break

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_start();
    t_aster();
    t_break();
    tally_and_finish();
  end
endmodule : test_line_transmit_sequencer

`default_nettype wire
